/* File: pkg/usb_hub_event_timer_defs.svh */
// timing constants and field widths for the hub event timer
`ifndef USB_HUB_EVENT_TIMER_DEFS_SVH
`define USB_HUB_EVENT_TIMER_DEFS_SVH

`define NUM_PORTS 4
`define CLK_MHZ 250
`define US_CYC `CLK_MHZ
`define TK_W 15
`define CYC_W 10
`define GAP_W 8

// short line filters, counted in clock cycles
`define T_FILT_NS 2500
`define FILT_CYC ((`T_FILT_NS * `CLK_MHZ + 999) / 1000)
`define T_DDIS_NS 2000
`define DDIS_CYC ((`T_DDIS_NS * `CLK_MHZ + 999) / 1000)

// long intervals, counted in microsecond ticks
`define T_DRSMDN_MS 20
`define DRSMDN_TK (`T_DRSMDN_MS * 1000 + 1)
`define T_DRST_MS 15
`define DRST_TK (`T_DRST_MS * 1000)
`define T_DCHBIT_US 50
`define DCHBIT_TK `T_DCHBIT_US
`define T_DCHSTOP_US 350
`define DCHSTOP_TK `T_DCHSTOP_US
`define T_WTRSM_MS 5
`define WTRSM_TK (`T_WTRSM_MS * 1000 + 1)
`define T_DRSMUP_MS 10
`define DRSMUP_TK (`T_DRSMUP_MS * 1000)
`define T_WTREV_US 3000
`define WTREV_TK (`T_WTREV_US + 1)
`define T_WTRSTHS_US 500
`define WTRSTHS_TK `T_WTRSTHS_US
`define T_UCH_US 2000
`define UCH_TK `T_UCH_US
`define T_WTFS_US 1500
`define WTFS_TK (`T_WTFS_US + 1)
`define HS_CHIRPS 6

// packet spacing in bit times, converted to clock cycles
`define HS_MBPS 480
`define FS_MBPS 12
`define GAP_HS_SD_BITS 88
`define GAP_HS_OD_BITS 8
`define GAP_FS_BITS 2
`define RSP_HS_BITS 192
`define RSP_FS_TENTHS 65
`define GAP_HS_SD_CYC ((`GAP_HS_SD_BITS * `CLK_MHZ + `HS_MBPS - 1) / `HS_MBPS)
`define GAP_HS_OD_CYC ((`GAP_HS_OD_BITS * `CLK_MHZ + `HS_MBPS - 1) / `HS_MBPS)
`define GAP_FS_CYC ((`GAP_FS_BITS * `CLK_MHZ + `FS_MBPS - 1) / `FS_MBPS)
`define RSP_HS_CYC ((`RSP_HS_BITS * `CLK_MHZ) / `HS_MBPS)
`define RSP_FS_CYC ((`RSP_FS_TENTHS * `CLK_MHZ) / (`FS_MBPS * 10))

`endif

/* File: pkg/usb_hub_event_timer_pkg.sv */
// types shared by the hub event timer modules
`include "usb_hub_event_timer_defs.svh"

package usb_hub_event_timer_pkg;

	typedef logic [`TK_W-1:0] tk_t;
	typedef logic [`CYC_W-1:0] cyc_t;
	typedef logic [`GAP_W-1:0] gap_t;

	typedef enum logic [1:0] {
		LS_SE0 = 2'b00,
		LS_J = 2'b01,
		LS_K = 2'b10,
		LS_SE1 = 2'b11
	} line_t;

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_RESET = 2'b01,
		DS_RESUME = 2'b10
	} ds_state_t;

	typedef enum logic [2:0] {
		US_FS = 3'b000,
		US_CHIRP = 3'b001,
		US_WAITHS = 3'b010,
		US_HS = 3'b011,
		US_REVWAIT = 3'b100,
		US_RESUME = 3'b101
	} us_state_t;

endpackage : usb_hub_event_timer_pkg

/* File: core/ds_port_timer.sv */
// downstream port timing: connect, disconnect, reset with chirps, resume
`include "usb_hub_event_timer_defs.svh"

module ds_port_timer
	import usb_hub_event_timer_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic [1:0] line,
	input wire logic reset_req,
	input wire logic resume_req,
	output logic connected,
	output logic connect_evt,
	output logic disconnect_evt,
	output logic resume_det,
	output logic drive_en,
	output logic [1:0] drive_line,
	output logic reset_busy
);

	typedef struct packed {
		ds_state_t state;
		tk_t tk;
		tk_t bit_tk;
		logic chirping;
		logic chirp_k;
		logic chirp_done;
		logic dev_k;
		logic [1:0] prev_line;
		cyc_t stab;
		logic connected;
		logic connect_evt;
		logic disconnect_evt;
		logic resume_det;
		logic drive_en;
		logic [1:0] drive_line;
	} ds_reg_t;

	ds_reg_t r_reg;
	ds_reg_t r_next;
	logic hit_dis;
	logic hit_flt;

	always_comb
	begin
		r_next = r_reg;
		r_next.connect_evt = 1'b0;
		r_next.disconnect_evt = 1'b0;
		r_next.resume_det = 1'b0;
		r_next.prev_line = line;
		// stable-line counter, restarts on any change
		if (line != r_reg.prev_line)
			r_next.stab = '0;
		else if (r_reg.stab != cyc_t'(`FILT_CYC))
			r_next.stab = r_reg.stab + cyc_t'(1);
		hit_dis = (r_next.stab == cyc_t'(`DDIS_CYC))
			&& (r_reg.stab != cyc_t'(`DDIS_CYC));
		hit_flt = (r_next.stab == cyc_t'(`FILT_CYC))
			&& (r_reg.stab != cyc_t'(`FILT_CYC));
		if (tick && (r_reg.tk != '1))
			r_next.tk = r_reg.tk + tk_t'(1);
		case (r_reg.state)
			DS_IDLE:
			begin
				r_next.drive_en = 1'b0;
				if (!r_reg.connected && hit_flt && (line != LS_SE0))
				begin
					r_next.connected = 1'b1;
					r_next.connect_evt = 1'b1;
				end
				if (r_reg.connected && hit_dis && (line == LS_SE0))
				begin
					r_next.connected = 1'b0;
					r_next.disconnect_evt = 1'b1;
				end
				if (r_reg.connected && hit_flt && (line == LS_K))
					r_next.resume_det = 1'b1;
				if (reset_req)
				begin
					r_next.state = DS_RESET;
					r_next.tk = '0;
					r_next.drive_en = 1'b1;
					r_next.drive_line = LS_SE0;
					r_next.chirping = 1'b0;
					r_next.chirp_done = 1'b0;
					r_next.dev_k = 1'b0;
				end
				else if (resume_req && r_reg.connected)
				begin
					r_next.state = DS_RESUME;
					r_next.tk = '0;
					r_next.drive_en = 1'b1;
					r_next.drive_line = LS_K;
				end
			end
			DS_RESET:
			begin
				if (hit_flt && (line == LS_K) && !r_reg.chirping)
					r_next.dev_k = 1'b1;
				// hub chirps start as soon as the device K ends
				if (r_reg.dev_k && !r_reg.chirping && !r_reg.chirp_done
					&& (line != LS_K))
				begin
					r_next.chirping = 1'b1;
					r_next.chirp_k = 1'b1;
					r_next.bit_tk = '0;
					r_next.drive_line = LS_K;
				end
				if (r_reg.chirping && tick)
				begin
					r_next.bit_tk = r_reg.bit_tk + tk_t'(1);
					if (r_reg.bit_tk == tk_t'(`DCHBIT_TK - 1))
					begin
						r_next.bit_tk = '0;
						if ((tk_t'(`DRST_TK) - r_reg.tk)
							<= tk_t'(`DCHSTOP_TK))
						begin
							r_next.chirping = 1'b0;
							r_next.chirp_done = 1'b1;
							r_next.drive_line = LS_SE0;
						end
						else
						begin
							r_next.chirp_k = !r_reg.chirp_k;
							r_next.drive_line = r_reg.chirp_k ? LS_J : LS_K;
						end
					end
				end
				if (r_reg.tk >= tk_t'(`DRST_TK))
				begin
					r_next.state = DS_IDLE;
					r_next.drive_en = 1'b0;
					r_next.drive_line = LS_SE0;
					r_next.chirping = 1'b0;
					// restart filter: a gone device leaves SE0 behind
					r_next.stab = '0;
				end
			end
			DS_RESUME:
			begin
				if (r_reg.tk >= tk_t'(`DRSMDN_TK))
				begin
					r_next.state = DS_IDLE;
					r_next.drive_en = 1'b0;
					r_next.drive_line = LS_SE0;
					r_next.stab = '0;
				end
			end
			default:
			begin
				r_next.state = DS_IDLE;
				r_next.drive_en = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign connected = r_reg.connected;
	assign connect_evt = r_reg.connect_evt;
	assign disconnect_evt = r_reg.disconnect_evt;
	assign resume_det = r_reg.resume_det;
	assign drive_en = r_reg.drive_en;
	assign drive_line = r_reg.drive_line;
	assign reset_busy = (r_reg.state == DS_RESET);

endmodule : ds_port_timer

/* File: core/usb_hub_event_timer.sv */
// hub event timer: upstream reset/chirp/resume control and downstream ports
//
// Behaviour
// - downstream connect seen after 2.5 us, well within 2000/12000 us
// - downstream disconnect recognised after 2.0 to 2.5 us of SE0
// - controlling hub drives downstream resume for at least 20 ms
// - downstream resume is rebroadcast upstream within 1.0 ms
// - port reset request drives reset for 10 to 20 ms
// - upstream K becomes long K after 2.5 us, within 100 us
// - upstream long SE0 detected between 2.5 us and 10000 us
// - high-speed packet gaps: 88 bits same direction, 8 opposite
// - high-speed response starts within 192 bit times
// - chirp J or K valid only after 2.5 us continuous
// - hub chirp K starts within 100 us of device chirp end
// - each downstream chirp J or K lasts 40 to 60 us
// - downstream chirps end 100 to 500 us before reset end
// - D+ pull-up asserted within 100 ms of power good
// - remote wakeup only after 5 ms of idle bus
// - upstream resume driven for 1 to 15 ms
// - non high-speed device detects upstream reset in 2.5 to 10000 us
// - full-speed gap at least 2 bits, response within 6.5 bits
// - handshake starts after at least 2.5 us continuous upstream SE0
// - high-speed hub reverts 3.0 to 3.125 ms after SE0 start
// - upstream chirp K lasts 2.0 ms, ends within 7.0 ms
// - high speed within 500 us, else full speed 1.0-2.5 ms later
`include "usb_hub_event_timer_defs.svh"

module usb_hub_event_timer
	import usb_hub_event_timer_pkg::*;
#(
	parameter int unsigned TICK_CYC = `US_CYC
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic power_good,
	input wire logic hs_capable,
	input wire logic [1:0] us_line,
	input wire logic wake_req,
	input wire logic pkt_end,
	input wire logic pkt_dir,
	input wire logic rsp_expected,
	input wire logic tx_req,
	input wire logic tx_dir,
	input wire logic [`NUM_PORTS-1:0][1:0] ds_line,
	input wire logic [`NUM_PORTS-1:0] ds_reset_req,
	input wire logic [`NUM_PORTS-1:0] ds_resume_req,
	output logic attach_pullup,
	output logic us_drive_en,
	output logic [1:0] us_drive_line,
	output logic hs_mode,
	output logic long_k_det,
	output logic long_se0_det,
	output logic bus_reset_det,
	output logic wake_busy,
	output logic tx_go,
	output logic rsp_late,
	output logic [`NUM_PORTS-1:0] ds_connected,
	output logic [`NUM_PORTS-1:0] ds_connect_evt,
	output logic [`NUM_PORTS-1:0] ds_disconnect_evt,
	output logic [`NUM_PORTS-1:0] ds_resume_det,
	output logic [`NUM_PORTS-1:0] ds_drive_en,
	output logic [`NUM_PORTS-1:0][1:0] ds_drive_line,
	output logic [`NUM_PORTS-1:0] ds_reset_busy
);

	localparam gap_t TICK_LAST = gap_t'(TICK_CYC - 1);

	typedef struct packed {
		us_state_t state;
		gap_t tick_cnt;
		logic tick;
		tk_t tk;
		tk_t se0_tk;
		tk_t idle_tk;
		logic [1:0] prev_line;
		cyc_t stab;
		logic chirp_exp_k;
		logic [2:0] chirp_cnt;
		logic hs;
		logic attach;
		logic drive_en;
		logic [1:0] drive_line;
		logic long_k;
		logic long_se0;
		logic bus_reset;
		logic rsm_ds;
		gap_t gap;
		logic last_dir;
		logic rsp_pend;
		logic rsp_late;
	} us_reg_t;

	us_reg_t r_reg;
	us_reg_t r_next;
	logic hit_flt;
	logic chirp_ok;
	logic link_free;
	gap_t gap_need;
	gap_t rsp_lim;
	logic [`NUM_PORTS-1:0] port_resume;

	// gap rules pick the spacing from speed and direction
	always_comb
	begin
		if (r_reg.hs)
		begin
			gap_need = (tx_dir == r_reg.last_dir) ?
				gap_t'(`GAP_HS_SD_CYC) : gap_t'(`GAP_HS_OD_CYC);
			rsp_lim = gap_t'(`RSP_HS_CYC);
		end
		else
		begin
			gap_need = gap_t'(`GAP_FS_CYC);
			rsp_lim = gap_t'(`RSP_FS_CYC);
		end
		link_free = !r_reg.drive_en
			&& ((r_reg.state == US_FS) || (r_reg.state == US_HS));
		tx_go = tx_req && link_free && (r_reg.gap >= gap_need);
	end

	always_comb
	begin
		r_next = r_reg;
		r_next.long_k = 1'b0;
		r_next.long_se0 = 1'b0;
		r_next.bus_reset = 1'b0;
		r_next.rsm_ds = 1'b0;
		r_next.rsp_late = 1'b0;
		// free-running microsecond tick
		r_next.tick = (r_reg.tick_cnt == TICK_LAST);
		r_next.tick_cnt = r_next.tick ? '0 : r_reg.tick_cnt + gap_t'(1);
		r_next.attach = power_good;
		r_next.prev_line = us_line;
		if (us_line != r_reg.prev_line)
			r_next.stab = '0;
		else if (r_reg.stab != cyc_t'(`FILT_CYC))
			r_next.stab = r_reg.stab + cyc_t'(1);
		hit_flt = (r_next.stab == cyc_t'(`FILT_CYC))
			&& (r_reg.stab != cyc_t'(`FILT_CYC));
		if (r_reg.tick && (r_reg.tk != '1))
			r_next.tk = r_reg.tk + tk_t'(1);
		if (us_line != LS_SE0)
			r_next.se0_tk = '0;
		else if (r_reg.tick && (r_reg.se0_tk != '1))
			r_next.se0_tk = r_reg.se0_tk + tk_t'(1);
		if ((us_line != LS_J) || r_reg.drive_en)
			r_next.idle_tk = '0;
		else if (r_reg.tick && (r_reg.idle_tk != tk_t'(`WTRSM_TK)))
			r_next.idle_tk = r_reg.idle_tk + tk_t'(1);
		if (!r_reg.drive_en && hit_flt)
		begin
			r_next.long_k = (us_line == LS_K);
			r_next.long_se0 = (us_line == LS_SE0) && !r_reg.hs;
			r_next.bus_reset = (us_line == LS_SE0) && !r_reg.hs
				&& !hs_capable;
			r_next.rsm_ds = (us_line == LS_K) && (r_reg.state == US_FS);
		end
		chirp_ok = hit_flt
			&& (us_line == (r_reg.chirp_exp_k ? LS_K : LS_J));
		case (r_reg.state)
			US_FS:
			begin
				r_next.hs = 1'b0;
				if (hit_flt && (us_line == LS_SE0) && hs_capable)
				begin
					r_next.state = US_CHIRP;
					r_next.tk = '0;
					r_next.drive_en = 1'b1;
					r_next.drive_line = LS_K;
				end
				else if (|ds_resume_det)
				begin
					r_next.state = US_RESUME;
					r_next.tk = '0;
					r_next.drive_en = 1'b1;
					r_next.drive_line = LS_K;
				end
				else if (wake_req
					&& (r_reg.idle_tk >= tk_t'(`WTRSM_TK)))
				begin
					r_next.state = US_RESUME;
					r_next.tk = '0;
					r_next.drive_en = 1'b1;
					r_next.drive_line = LS_K;
				end
			end
			US_CHIRP:
			begin
				if (r_reg.tk >= tk_t'(`UCH_TK))
				begin
					r_next.state = US_WAITHS;
					r_next.tk = '0;
					r_next.drive_en = 1'b0;
					r_next.drive_line = LS_SE0;
					r_next.chirp_cnt = '0;
					r_next.chirp_exp_k = 1'b1;
				end
			end
			US_WAITHS:
			begin
				if (chirp_ok)
				begin
					r_next.chirp_cnt = r_reg.chirp_cnt + 3'(1);
					r_next.chirp_exp_k = !r_reg.chirp_exp_k;
				end
				if (chirp_ok && (r_reg.chirp_cnt == 3'(`HS_CHIRPS - 1)))
				begin
					r_next.state = US_HS;
					r_next.hs = 1'b1;
				end
				else if (r_reg.tk >= tk_t'(`WTFS_TK))
					r_next.state = US_FS;
			end
			US_HS:
			begin
				r_next.hs = 1'b1;
				if (r_reg.se0_tk >= tk_t'(`WTREV_TK))
				begin
					r_next.state = US_REVWAIT;
					r_next.hs = 1'b0;
					r_next.tk = '0;
				end
			end
			US_REVWAIT:
			begin
				// sample the bus after reverting: SE0 means reset
				if (r_reg.tk >= tk_t'(`WTRSTHS_TK))
				begin
					if (us_line == LS_SE0)
					begin
						r_next.state = US_CHIRP;
						r_next.tk = '0;
						r_next.drive_en = 1'b1;
						r_next.drive_line = LS_K;
					end
					else
						r_next.state = US_FS;
				end
			end
			US_RESUME:
			begin
				if (r_reg.tk >= tk_t'(`DRSMUP_TK))
				begin
					r_next.state = US_FS;
					r_next.drive_en = 1'b0;
					r_next.drive_line = LS_SE0;
				end
			end
			default:
			begin
				r_next.state = US_FS;
				r_next.drive_en = 1'b0;
			end
		endcase
		// inter-packet spacing and response window
		if (pkt_end)
		begin
			r_next.gap = '0;
			r_next.last_dir = pkt_dir;
			r_next.rsp_pend = rsp_expected;
		end
		else
		begin
			if (r_reg.gap != '1)
				r_next.gap = r_reg.gap + gap_t'(1);
			if (tx_go)
				r_next.rsp_pend = 1'b0;
			else if (r_reg.rsp_pend && (r_reg.gap == rsp_lim))
			begin
				r_next.rsp_pend = 1'b0;
				r_next.rsp_late = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	// host resume on upstream is repeated onto every connected port
	assign port_resume = ds_resume_req | {`NUM_PORTS{r_reg.rsm_ds}};

	genvar p;
	generate
		for (p = 0; p < `NUM_PORTS; p++)
		begin : g_port
			ds_port_timer u_port (
				.clk(clk),
				.nrst(nrst),
				.tick(r_reg.tick),
				.line(ds_line[p]),
				.reset_req(ds_reset_req[p]),
				.resume_req(port_resume[p]),
				.connected(ds_connected[p]),
				.connect_evt(ds_connect_evt[p]),
				.disconnect_evt(ds_disconnect_evt[p]),
				.resume_det(ds_resume_det[p]),
				.drive_en(ds_drive_en[p]),
				.drive_line(ds_drive_line[p]),
				.reset_busy(ds_reset_busy[p])
			);
		end
	endgenerate

	assign attach_pullup = r_reg.attach;
	assign us_drive_en = r_reg.drive_en;
	assign us_drive_line = r_reg.drive_line;
	assign hs_mode = r_reg.hs;
	assign long_k_det = r_reg.long_k;
	assign long_se0_det = r_reg.long_se0;
	assign bus_reset_det = r_reg.bus_reset;
	assign wake_busy = (r_reg.state == US_RESUME);
	assign rsp_late = r_reg.rsp_late;

endmodule : usb_hub_event_timer

/* File: test/usb_hub_event_timer_assertions.sv */
// port assertions for the hub event timer
`include "usb_hub_event_timer_defs.svh"

module usb_hub_event_timer_assertions
	import usb_hub_event_timer_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic hs_capable,
	input wire logic [1:0] us_line,
	input wire logic pkt_end,
	input wire logic [`NUM_PORTS-1:0][1:0] ds_line,
	input wire logic [`NUM_PORTS-1:0] ds_reset_req,
	input wire logic us_drive_en,
	input wire logic [1:0] us_drive_line,
	input wire logic hs_mode,
	input wire logic long_k_det,
	input wire logic long_se0_det,
	input wire logic bus_reset_det,
	input wire logic tx_go,
	input wire logic [`NUM_PORTS-1:0] ds_connect_evt,
	input wire logic [`NUM_PORTS-1:0] ds_disconnect_evt,
	input wire logic [`NUM_PORTS-1:0] ds_drive_en,
	input wire logic [`NUM_PORTS-1:0][1:0] ds_drive_line,
	input wire logic [`NUM_PORTS-1:0] ds_reset_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	property p_port_reset;
		ds_reset_req[0] && !ds_reset_busy[0] && !ds_drive_en[0] |=>
			ds_reset_busy[0] && ds_drive_en[0] && ds_drive_line[0] == LS_SE0;
	endproperty
	a_port_reset: assert property (p_port_reset)
		else $error("port reset not started");
	property p_long_k;
		long_k_det |-> $past(us_line, 8) == LS_K && $past(us_line) == LS_K;
	endproperty
	a_long_k: assert property (p_long_k)
		else $error("long K without K");
	property p_long_se0;
		long_se0_det |-> !hs_mode && $past(us_line, 8) == LS_SE0;
	endproperty
	a_long_se0: assert property (p_long_se0)
		else $error("long SE0 without SE0");
	property p_bus_reset;
		bus_reset_det |-> !hs_capable && $past(us_line, 8) == LS_SE0;
	endproperty
	a_bus_reset: assert property (p_bus_reset)
		else $error("bus reset flagged wrongly");
	property p_connect;
		ds_connect_evt[0] |-> $past(ds_line[0], 8) != LS_SE0;
	endproperty
	a_connect: assert property (p_connect)
		else $error("connect on SE0");
	property p_disconnect;
		ds_disconnect_evt[0] |-> $past(ds_line[0], 8) == LS_SE0;
	endproperty
	a_disconnect: assert property (p_disconnect)
		else $error("disconnect without SE0");
	property p_gap;
		pkt_end |=> !tx_go [*5];
	endproperty
	a_gap: assert property (p_gap)
		else $error("packet started too soon");
	property p_chirp;
		$rose(us_drive_en) |-> (us_drive_en && us_drive_line == LS_K) [*8];
	endproperty
	a_chirp: assert property (p_chirp)
		else $error("upstream K not held");
	c_hs: cover property ($rose(hs_mode));
	c_reset: cover property (ds_reset_req[0]);
	c_se0: cover property (long_se0_det);
endmodule : usb_hub_event_timer_assertions

bind usb_hub_event_timer usb_hub_event_timer_assertions u_chk (
	.clk(clk), .nrst(nrst), .hs_capable(hs_capable),
	.us_line(us_line), .pkt_end(pkt_end), .ds_line(ds_line),
	.ds_reset_req(ds_reset_req), .us_drive_en(us_drive_en),
	.us_drive_line(us_drive_line), .hs_mode(hs_mode),
	.long_k_det(long_k_det), .long_se0_det(long_se0_det),
	.bus_reset_det(bus_reset_det), .tx_go(tx_go),
	.ds_connect_evt(ds_connect_evt),
	.ds_disconnect_evt(ds_disconnect_evt),
	.ds_drive_en(ds_drive_en), .ds_drive_line(ds_drive_line),
	.ds_reset_busy(ds_reset_busy)
);

/* File: test/usb_far_side.sv */
// far side model: upstream host and device on port 0
module usb_far_side
	import usb_hub_event_timer_pkg::*;
(
	input wire logic clk,
	input wire logic us_drive_en,
	input wire logic [1:0] us_drive_line,
	input wire logic ds_drive_en,
	input wire logic [1:0] ds_drive_line,
	output logic [1:0] us_line,
	output logic [1:0] ds_line0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] host_line = LS_J;
	logic [1:0] dev_line = LS_SE0;
	logic dev_k = 1'H0;
	assign us_line = us_drive_en ? us_drive_line : host_line;
	assign ds_line0 = dev_k ? LS_K : ds_drive_en ? ds_drive_line : dev_line;
	// host answer after a short SE0: three K-J pairs, each K and each J 2.56 us
	task host_chirp;
		repeat (25) @(negedge clk);
		repeat (3)
		begin
			host_line = LS_K;
			repeat (640) @(negedge clk);
			host_line = LS_J;
			repeat (640) @(negedge clk);
		end
		host_line = LS_SE0;
	endtask : host_chirp
	task dev_chirp;
		dev_k = 1'H1;
		repeat (700) @(negedge clk);
		dev_k = 1'H0;
	endtask : dev_chirp
endmodule : usb_far_side

/* File: test/usb_hub_event_timer_tb.sv */
// self-checking bench for the hub event timer
`include "usb_hub_event_timer_defs.svh"

module usb_hub_event_timer_tb
	import usb_hub_event_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, power_good, hs_capable, wake_req, pkt_end, pkt_dir;
	logic rsp_expected, tx_req, tx_dir, attach_pullup, us_drive_en, hs_mode;
	logic long_k_det, long_se0_det, bus_reset_det, wake_busy, tx_go, rsp_late;
	logic [1:0] us_line, us_drive_line, ds_l0;
	logic [3:0] ds_reset_req, ds_resume_req, ds_connected, ds_connect_evt;
	logic [3:0] ds_disconnect_evt, ds_resume_det, ds_drive_en, ds_reset_busy;
	logic [3:0][1:0] ds_line, ds_drive_line;
	int fails = 0;
	int total_checks = 0;
	int n, a, q;
	longint t0;
	assign ds_line = {6'H00, ds_l0};
	usb_hub_event_timer #(.TICK_CYC(3)) u_dut (
		.clk(clk), .nrst(nrst), .power_good(power_good),
		.hs_capable(hs_capable), .us_line(us_line),
		.wake_req(wake_req), .pkt_end(pkt_end), .pkt_dir(pkt_dir),
		.rsp_expected(rsp_expected), .tx_req(tx_req),
		.tx_dir(tx_dir), .ds_line(ds_line),
		.ds_reset_req(ds_reset_req), .ds_resume_req(ds_resume_req),
		.attach_pullup(attach_pullup), .us_drive_en(us_drive_en),
		.us_drive_line(us_drive_line), .hs_mode(hs_mode),
		.long_k_det(long_k_det), .long_se0_det(long_se0_det),
		.bus_reset_det(bus_reset_det), .wake_busy(wake_busy),
		.tx_go(tx_go), .rsp_late(rsp_late),
		.ds_connected(ds_connected), .ds_connect_evt(ds_connect_evt),
		.ds_disconnect_evt(ds_disconnect_evt),
		.ds_resume_det(ds_resume_det), .ds_drive_en(ds_drive_en),
		.ds_drive_line(ds_drive_line), .ds_reset_busy(ds_reset_busy));
	usb_far_side u_far (.clk(clk), .us_drive_en(us_drive_en),
		.us_drive_line(us_drive_line), .ds_drive_en(ds_drive_en[0]),
		.ds_drive_line(ds_drive_line[0]), .us_line(us_line), .ds_line0(ds_l0));
	initial
	begin
		clk = 1'H0;
		forever #2 clk = ~clk;
	end
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task chk(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %0d seen %0d", what, exp, seen);
		end
	endtask : chk
	task rng(input string what, input int v, lo, hi);
		chk(what, 32'(v >= lo && v <= hi), 32'H1);
	endtask : rng
	task tmo(input int lim);
		if (n >= lim)
		begin
			fails++;
			$display("BAD wait expected event seen timeout");
			summarize;
		end
	endtask : tmo
	task pkt(input logic rsp);
		pkt_end = 1'H1;
		rsp_expected = rsp;
		@(negedge clk);
		pkt_end = 1'H0;
	endtask : pkt
	task gap(input logic dir, input int need);
		pkt(1'H0);
		tx_dir = dir;
		tx_req = 1'H1;
		for (n = 0; n < 300 && tx_go !== 1'H1; n++) @(negedge clk);
		tmo(300);
		// hold the request through the edge that takes tx_go
		@(negedge clk);
		tx_req = 1'H0;
		rng("tx gap", n, need, need + 1);
		$display("gap test done");
	endtask : gap
	task t_fs_reset;
		u_far.host_line = LS_SE0;
		for (n = 0; n < 2000 && bus_reset_det !== 1'H1; n++) @(negedge clk);
		tmo(2000);
		rng("bus reset", n, 625, 30000);
		u_far.host_line = LS_J;
		$display("fs reset done");
	endtask : t_fs_reset
	task t_port;
		u_far.dev_line = LS_J;
		for (n = 0; n < 900 && ds_connect_evt[0] !== 1'H1; n++) @(negedge clk);
		tmo(900);
		rng("connect", n, 625, 6000);
		ds_reset_req[0] = 1'H1;
		@(negedge clk);
		ds_reset_req[0] = 1'H0;
		chk("reset busy", ds_reset_busy[0], 1'H1);
		chk("reset line", ds_drive_line[0], LS_SE0);
		u_far.dev_chirp();
		for (n = 0; n < 400 && ds_drive_line[0] !== LS_K; n++) @(negedge clk);
		rng("chirp start", n, 0, 300);
		for (a = 0; a < 400 && ds_drive_line[0] === LS_K; a++) @(negedge clk);
		rng("chirp bit", a, 120, 180);
		q = 0;
		for (n = n + a + 702; n < 70000 && ds_reset_busy[0] === 1'H1; n++)
		begin
			q = ds_drive_line[0] === LS_SE0 ? q + 1 : 0;
			@(negedge clk);
		end
		rng("reset len", n, 30000, 60000);
		rng("chirp stop", q, 300, 1500);
		u_far.dev_line = LS_SE0;
		for (n = 0; n < 700 && ds_disconnect_evt[0] !== 1'H1; n++)
			@(negedge clk);
		tmo(700);
		rng("disconnect", n, 500, 625);
		$display("port test done");
	endtask : t_port
	task t_longk;
		u_far.host_line = LS_K;
		for (n = 0; n < 1000 && long_k_det !== 1'H1; n++) @(negedge clk);
		tmo(1000);
		rng("long K", n, 625, 25000);
		u_far.host_line = LS_J;
		$display("long K done");
	endtask : t_longk
	task t_resume;
		wake_req = 1'H1;
		@(negedge clk);
		wake_req = 1'H0;
		chk("wake refused", wake_busy, 1'H0);
		u_far.dev_line = LS_J;
		for (n = 0; n < 900 && ds_connect_evt[0] !== 1'H1; n++)
			@(negedge clk);
		tmo(900);
		chk("connected", ds_connected[0], 1'H1);
		u_far.dev_line = LS_K;
		for (n = 0; n < 900 && ds_resume_det[0] !== 1'H1; n++)
			@(negedge clk);
		tmo(900);
		for (n = 0; n < 3100 && wake_busy !== 1'H1; n++) @(negedge clk);
		rng("rebroadcast", n, 0, 3000);
		chk("resume line", us_drive_line, LS_K);
		for (a = 0; a < 46000 && wake_busy === 1'H1; a++) @(negedge clk);
		rng("resume len", a, 3000, 45000);
		u_far.dev_line = LS_J;
		@(negedge clk);
		ds_resume_req[0] = 1'H1;
		@(negedge clk);
		ds_resume_req[0] = 1'H0;
		chk("port resume en", ds_drive_en[0], 1'H1);
		chk("port resume K", ds_drive_line[0], LS_K);
		$display("resume test done");
	endtask : t_resume
	task t_hs;
		hs_capable = 1'H1;
		u_far.host_line = LS_SE0;
		for (n = 0; n < 2000 && us_drive_en !== 1'H1; n++) @(negedge clk);
		tmo(2000);
		rng("hs start", n, 625, 2000);
		chk("chirp line", us_drive_line, LS_K);
		for (a = 0; a < 30000 && us_drive_en === 1'H1; a++) @(negedge clk);
		rng("chirp len", a, 3000, 21000 - n);
		u_far.host_chirp();
		t0 = $time;
		for (n = 0; n < 1500 && hs_mode !== 1'H1; n++) @(negedge clk);
		tmo(1500);
		gap(1'H0, `GAP_HS_SD_CYC);
		gap(1'H1, `GAP_HS_OD_CYC);
		pkt(1'H1);
		for (n = 0; n < 300 && rsp_late !== 1'H1; n++) @(negedge clk);
		tmo(300);
		rng("rsp limit", n, `RSP_HS_CYC - 1, `RSP_HS_CYC + 1);
		for (n = 0; n < 12000 && hs_mode === 1'H1; n++) @(negedge clk);
		tmo(12000);
		rng("revert", int'(($time - t0) / 4), 9000, 9375);
		$display("hs test done");
	endtask : t_hs
	initial
	begin
		nrst = 1'H0;
		power_good = 1'H1;
		{hs_capable, wake_req, pkt_end, pkt_dir} = 4'H0;
		{rsp_expected, tx_req, tx_dir} = 3'H0;
		ds_reset_req = 4'H0;
		ds_resume_req = 4'H0;
		repeat (5) @(negedge clk);
		nrst = 1'H1;
		@(negedge clk);
		chk("pullup", attach_pullup, 1'H1);
		t_fs_reset;
		gap(1'H0, `GAP_FS_CYC);
		t_port;
		t_longk;
		t_resume;
		t_hs;
		summarize;
	end
endmodule : usb_hub_event_timer_tb
